// >>> rtl/ieg_gate.sv
// Combinational gate: passes each source request through its enable bit
// and the global enable. Assumes requests are already synchronous levels.
`timescale 1ns/1ps
module ieg_gate (
    input  wire ieg_pkg::ieg_main_s i_main,
    input  wire ieg_pkg::ieg_ext_s  i_ext,
    input  wire ieg_pkg::ieg_src_s  i_req,
    output ieg_pkg::ieg_src_s       o_req
);

    logic [ieg_pkg::IEG_NSRC-1:0] en_vec;

    // Per-source enables line up with the source struct
    assign en_vec = {i_ext, i_main[ieg_pkg::IEG_BIT_GLOBAL-1:0]};

    // Gate and check in one process so the check never sees a stale output
    always_comb begin
        o_req = '0;
        if (i_main.global_irq_enable) begin
            o_req = i_req & en_vec;
        end
        a_gate_global_off: assert (i_main.global_irq_enable || o_req == '0)
            else $error("request passed while global enable is clear");
    end

endmodule

// >>> rtl/ieg_pkg.sv
// Package for the interrupt enable gating block: addresses, reset values,
// field layouts of both enable registers and the bus and source carriers.
// Assumes one clock domain and an 8-bit special register port.
package ieg_pkg;

    localparam logic [7:0] IEG_ADDR_EXT     = 8'hA7;
    localparam logic [7:0] IEG_ADDR_MAIN    = 8'hA8;
    localparam logic [7:0] IEG_RST_MAIN     = 8'h00;
    localparam logic [7:0] IEG_RST_EXT      = 8'h00;
    localparam logic [7:0] IEG_RDATA_NONE   = 8'h00;
    // Bit addresses of the main register are its byte address plus the bit index
    localparam logic [4:0] IEG_BITADDR_BASE = 5'h15;
    localparam int         IEG_BIT_GLOBAL   = 7;
    localparam int         IEG_NSRC         = 15;

    typedef struct packed {
        logic global_irq_enable;
        logic pca_irq_enable;
        logic timer2_irq_enable;
        logic serial_irq_enable;
        logic timer1_irq_enable;
        logic ext_int1_irq_enable;
        logic timer0_irq_enable;
        logic ext_int0_irq_enable;
    } ieg_main_s;

    typedef struct packed {
        logic adc_irq_enable;
        logic ext_int6_irq_enable;
        logic ext_int5_irq_enable;
        logic ext_int4_irq_enable;
        logic ext_int3_irq_enable;
        logic ext_int2_irq_enable;
        logic pca1_irq_enable;
        logic serial_expansion_irq_enable;
    } ieg_ext_s;

    // Same order as the extended register followed by main bits 6..0
    typedef struct packed {
        logic adc;
        logic ext6;
        logic ext5;
        logic ext4;
        logic ext3;
        logic ext2;
        logic pca1;
        logic serial_exp;
        logic pca;
        logic timer2;
        logic serial;
        logic timer1;
        logic ext1;
        logic timer0;
        logic ext0;
    } ieg_src_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ieg_bus_s;

endpackage

// >>> rtl/ieg_top.sv
// Interrupt enable gating: main and extended enable registers on a plain
// byte-wide register port, with bit writes into the main register.
// Assumes synchronous source request levels and a single 200 MHz clock.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module ieg_top (
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    input  wire ieg_pkg::ieg_bus_s i_bus,
    input  wire logic              i_bit_wr,
    input  wire logic [7:0]        i_bit_addr,
    input  wire logic              i_bit_val,
    input  wire ieg_pkg::ieg_src_s i_src_req,
    output logic [7:0]             o_rdata,
    output ieg_pkg::ieg_src_s      o_irq_req,
    output logic                   o_irq_any,
    output ieg_pkg::ieg_main_s     o_ie_main,
    output ieg_pkg::ieg_ext_s      o_ie_ext
);

    ieg_pkg::ieg_main_s main_r;
    ieg_pkg::ieg_main_s main_nxt;
    ieg_pkg::ieg_ext_s  ext_r;
    ieg_pkg::ieg_ext_s  ext_nxt;
    ieg_pkg::ieg_src_s  gated;
    logic [7:0]         rdata_nxt;
    logic               bit_hit;
    logic [2:0]         bit_idx;

    function automatic logic hit_main(input logic [7:0] addr);
        hit_main = (addr == ieg_pkg::IEG_ADDR_MAIN);
    endfunction

    function automatic logic hit_ext(input logic [7:0] addr);
        hit_ext = (addr == ieg_pkg::IEG_ADDR_EXT);
    endfunction

    // Bit writes reach only the main register
    assign bit_hit = i_bit_wr && (i_bit_addr[7:3] == ieg_pkg::IEG_BITADDR_BASE);
    assign bit_idx = i_bit_addr[2:0];

    // Main register: a byte write wins over a bit write in the same cycle
    always_comb begin
        main_nxt = main_r;
        if (i_bus.wr && hit_main(i_bus.addr)) begin
            main_nxt = i_bus.wdata;
        end else if (bit_hit) begin
            main_nxt[bit_idx] = i_bit_val;
        end
    end

    always_comb begin
        ext_nxt = ext_r;
        if (i_bus.wr && hit_ext(i_bus.addr)) begin
            ext_nxt = i_bus.wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            main_r <= ieg_pkg::IEG_RST_MAIN;
        end else begin
            main_r <= main_nxt;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_r <= ieg_pkg::IEG_RST_EXT;
        end else begin
            ext_r <= ext_nxt;
        end
    end

    // Read data: stored value, unmapped addresses read zero
    always_comb begin
        rdata_nxt = ieg_pkg::IEG_RDATA_NONE;
        if (hit_main(i_bus.addr)) begin
            rdata_nxt = main_r;
        end else if (hit_ext(i_bus.addr)) begin
            rdata_nxt = ext_r;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= ieg_pkg::IEG_RDATA_NONE;
        end else if (i_bus.rd) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= ieg_pkg::IEG_RDATA_NONE;
        end
    end

    ieg_gate u_gate (
        .i_main (main_r),
        .i_ext  (ext_r),
        .i_req  (i_src_req),
        .o_req  (gated)
    );

    // Gated requests toward priority logic, one cycle after sampling
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq_req <= '0;
        end else begin
            o_irq_req <= gated;
        end
    end

    // Summary request, registered alongside the per-source requests
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq_any <= 1'b0;
        end else begin
            o_irq_any <= |gated;
        end
    end

    // Register copies, loaded together with the registers themselves
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ie_main <= ieg_pkg::IEG_RST_MAIN;
        end else begin
            o_ie_main <= main_nxt;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ie_ext <= ieg_pkg::IEG_RST_EXT;
        end else begin
            o_ie_ext <= ext_nxt;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    a_global_blocks_all: assert property (
        !main_r.global_irq_enable |=> o_irq_req == '0)
        else $error("request leaked with global enable clear");

    a_source_follows_bit: assert property (
        main_r.global_irq_enable |=>
            o_irq_req == ($past(i_src_req) & {$past(ext_r), $past(main_r[6:0])}))
        else $error("gated request does not match enables");

    a_bit_one_allows: assert property (
        main_r.global_irq_enable && main_r.timer2_irq_enable && i_src_req.timer2
            |=> o_irq_req.timer2 && o_irq_any)
        else $error("enabled timer 2 request was blocked");

    a_ext_gate_split: assert property (
        1'b1 |=> (o_irq_req.ext1 == $past(i_src_req.ext1 && main_r.ext_int1_irq_enable
                                           && main_r.global_irq_enable))
              && (o_irq_req.ext4 == $past(i_src_req.ext4 && ext_r.ext_int4_irq_enable
                                           && main_r.global_irq_enable)))
        else $error("external interrupt gated by wrong bit");

    a_timer_gate: assert property (
        !main_r.timer0_irq_enable && !main_r.timer1_irq_enable
            |=> !o_irq_req.timer0 && !o_irq_req.timer1)
        else $error("timer request passed while its enable is clear");

    a_pca_gate_split: assert property (
        main_r.global_irq_enable && i_src_req.pca1 && i_src_req.pca
            |=> (o_irq_req.pca1 == $past(ext_r.pca1_irq_enable))
             && (o_irq_req.pca == $past(main_r.pca_irq_enable)))
        else $error("counter array request gated by wrong bit");

    a_serial_gate: assert property (
        main_r.global_irq_enable && i_src_req.serial && !main_r.serial_irq_enable
            |=> !o_irq_req.serial)
        else $error("serial request passed while disabled");

    a_byte_write_main: assert property (
        i_bus.wr && hit_main(i_bus.addr) |=> main_r == $past(i_bus.wdata)
                                          && o_ie_main == main_r)
        else $error("main register write lost");

    a_byte_write_ext: assert property (
        i_bus.wr && hit_ext(i_bus.addr) |=> ext_r == $past(i_bus.wdata))
        else $error("extended register write lost");

    a_bit_write_global: assert property (
        bit_hit && bit_idx == 3'h7 && !(i_bus.wr && hit_main(i_bus.addr))
            |=> main_r.global_irq_enable == $past(i_bit_val))
        else $error("global enable bit write lost");

    a_read_layout: assert property (
        i_bus.rd && hit_ext(i_bus.addr) |=> o_rdata == $past(ext_r)
                                         ##1 o_rdata == ieg_pkg::IEG_RDATA_NONE
                                             || $past(i_bus.rd))
        else $error("extended register read data wrong");

    a_read_unmapped: assert property (
        i_bus.rd && !hit_main(i_bus.addr) && !hit_ext(i_bus.addr)
            |=> o_rdata == ieg_pkg::IEG_RDATA_NONE)
        else $error("unmapped read returned data");

    // Checks on register upkeep
    a_read_main: assert property (
        i_bus.rd && hit_main(i_bus.addr) |=> o_rdata == $past(main_r))
        else $error("main register read data wrong");

    a_read_idle_zero: assert property (
        !i_bus.rd |=> o_rdata == ieg_pkg::IEG_RDATA_NONE)
        else $error("read data shown without a read");

    a_ie_main_copy: assert property (
        o_ie_main == main_r)
        else $error("main register copy differs");

    a_ie_ext_copy: assert property (
        o_ie_ext == ext_r)
        else $error("extended register copy differs");

    a_bit_write_other: assert property (
        bit_hit && !(i_bus.wr && hit_main(i_bus.addr))
            |=> main_r[$past(bit_idx)] == $past(i_bit_val))
        else $error("bit write did not land");

    a_bit_write_ignored: assert property (
        i_bit_wr && !bit_hit && !(i_bus.wr && hit_main(i_bus.addr))
            |=> $stable(main_r))
        else $error("bit write outside main register landed");

    a_ext_byte_only: assert property (
        !(i_bus.wr && hit_ext(i_bus.addr)) |=> $stable(ext_r))
        else $error("extended register changed without a byte write");

    a_byte_beats_bit: assert property (
        i_bus.wr && hit_main(i_bus.addr) && bit_hit |=> main_r == $past(i_bus.wdata))
        else $error("bit write overrode a same-cycle byte write");

    a_unmapped_write: assert property (
        i_bus.wr && !hit_main(i_bus.addr) && !hit_ext(i_bus.addr) && !bit_hit
            |=> $stable(main_r) && $stable(ext_r))
        else $error("write to an unmapped address landed");

    // Checks on the summary request and per-source gating
    a_any_matches_req: assert property (
        o_irq_any == (o_irq_req != '0))
        else $error("summary request disagrees with gated requests");

    a_global_clear_any: assert property (
        !main_r.global_irq_enable |=> !o_irq_any)
        else $error("summary request raised with global enable clear");

    a_any_idle: assert property (
        i_src_req == '0 |=> !o_irq_any)
        else $error("summary request raised with no source requesting");

    a_ext0_gate: assert property (
        main_r.global_irq_enable && i_src_req.ext0
            |=> o_irq_req.ext0 == $past(main_r.ext_int0_irq_enable))
        else $error("external interrupt 0 gated by wrong bit");

    a_ext_upper_gate: assert property (
        main_r.global_irq_enable
            |=> (o_irq_req.ext2 == $past(i_src_req.ext2 && ext_r.ext_int2_irq_enable))
             && (o_irq_req.ext3 == $past(i_src_req.ext3 && ext_r.ext_int3_irq_enable))
             && (o_irq_req.ext5 == $past(i_src_req.ext5 && ext_r.ext_int5_irq_enable))
             && (o_irq_req.ext6 == $past(i_src_req.ext6 && ext_r.ext_int6_irq_enable)))
        else $error("upper external interrupt gated by wrong bit");

    a_timer_pass: assert property (
        main_r.global_irq_enable && main_r.timer0_irq_enable && main_r.timer1_irq_enable
            && i_src_req.timer0 && i_src_req.timer1
            |=> o_irq_req.timer0 && o_irq_req.timer1)
        else $error("enabled timer request was blocked");

    a_timer2_gate: assert property (
        main_r.global_irq_enable && i_src_req.timer2
            |=> o_irq_req.timer2 == $past(main_r.timer2_irq_enable))
        else $error("timer 2 request gated by wrong bit");

    a_serial_pass: assert property (
        main_r.global_irq_enable && main_r.serial_irq_enable && i_src_req.serial
            |=> o_irq_req.serial)
        else $error("enabled serial request was blocked");

    a_serial_exp_gate: assert property (
        main_r.global_irq_enable && i_src_req.serial_exp
            |=> o_irq_req.serial_exp == $past(ext_r.serial_expansion_irq_enable))
        else $error("serial expansion request gated by wrong bit");

    a_adc_gate: assert property (
        main_r.global_irq_enable && i_src_req.adc
            |=> o_irq_req.adc == $past(ext_r.adc_irq_enable))
        else $error("converter request gated by wrong bit");

    a_bit_zero_blocks: assert property (
        !ext_r.adc_irq_enable && !main_r.ext_int0_irq_enable
            |=> !o_irq_req.adc && !o_irq_req.ext0)
        else $error("request passed while its enable bit is clear");

endmodule

// >>> verif/ieg_src_model.sv
// Model of the interrupt sources: request levels follow a pattern
// chosen by the bench, changing just after a rising clock edge.
// Assumes the same clock and active-low reset as the gating block.
`timescale 1ns/1ps
module ieg_src_model (
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic [14:0]  i_pattern,
    output ieg_pkg::ieg_src_s o_req
);
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_req <= '0;
        end else begin
            o_req <= ieg_pkg::ieg_src_s'(i_pattern);
        end
    end
endmodule

// >>> verif/ieg_top_tb_top.sv
// Self-checking bench for the interrupt enable gating block.
// Assumes a 200 MHz clock and the byte register port with bit writes.
`timescale 1ns/1ps
module ieg_top_tb_top;
    logic               i_ref_clk;
    logic               i_nrst;
    logic               bit_wr;
    logic               bit_val;
    logic [7:0]         bit_addr;
    logic [14:0]        pattern;
    logic [7:0]         rdata;
    logic               irq_any;
    ieg_pkg::ieg_bus_s  bus;
    ieg_pkg::ieg_src_s  src_req;
    ieg_pkg::ieg_src_s  irq_req;
    ieg_pkg::ieg_main_s ie_main;
    ieg_pkg::ieg_ext_s  ie_ext;
    int                 fails;
    int                 n_compared;

    ieg_src_model src_u (.i_clk(i_ref_clk), .i_nrst(i_nrst), .i_pattern(pattern),
                         .o_req(src_req));
    ieg_top dut_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(bus),
                   .i_bit_wr(bit_wr), .i_bit_addr(bit_addr), .i_bit_val(bit_val),
                   .i_src_req(src_req), .o_rdata(rdata), .o_irq_req(irq_req),
                   .o_irq_any(irq_any), .o_ie_main(ie_main), .o_ie_ext(ie_ext));

    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge i_ref_clk);
        bus.wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge i_ref_clk);
        bus.rd   <= 1'b0;
        @(negedge i_ref_clk);
        check({7'h00, rdata}, {7'h00, exp});
    endtask

    task automatic bw(input logic [7:0] a, input logic v, input logic [7:0] exp);
        @(posedge i_ref_clk);
        bit_addr <= a;
        bit_val  <= v;
        bit_wr   <= 1'b1;
        @(posedge i_ref_clk);
        bit_wr   <= 1'b0;
        @(negedge i_ref_clk);
        check({7'h00, ie_main}, {7'h00, exp});
    endtask

    // Program both registers, raise the request pattern, compare gated output
    task automatic gate(input logic [7:0] m, input logic [7:0] e, input logic [14:0] p,
                        input logic [14:0] x);
        wr(ieg_pkg::IEG_ADDR_MAIN, m);
        wr(ieg_pkg::IEG_ADDR_EXT, e);
        pattern <= p;
        repeat (3) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        check(irq_req, x);
        check({14'h0000, irq_any}, {14'h0000, |x});
    endtask

    task automatic end_of_test;
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        fails = 0;
        n_compared = 0;
        i_nrst = 1'b0;
        bus = '0;
        bit_wr = 1'b0;
        bit_val = 1'b0;
        bit_addr = 8'h00;
        pattern = 15'h0000;
        repeat (2) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        rd(ieg_pkg::IEG_ADDR_MAIN, 8'h00);
        rd(ieg_pkg::IEG_ADDR_EXT, 8'h00);
        for (int i = 0; i < 15; i++) begin
            gate(8'h80 | ((i < 7) ? 8'(1 << i) : 8'h00),
                 (i >= 7) ? 8'(1 << (i - 7)) : 8'h00, 15'h7FFF, 15'(1 << i));
            gate(8'h80 | ((i < 7) ? ~8'(1 << i) : 8'hFF),
                 (i >= 7) ? ~8'(1 << (i - 7)) : 8'hFF, 15'h7FFF, ~15'(1 << i));
        end
        gate(8'h85, 8'h54, 15'h3E05, 15'h2A05);
        gate(8'h8A, 8'h00, 15'h000F, 15'h000A);
        gate(8'hC0, 8'h02, 15'h0340, 15'h0140);
        gate(8'h90, 8'h01, 15'h00B0, 15'h0090);
        gate(8'h7F, 8'hFF, 15'h7FFF, 15'h0000);
        gate(8'h80, 8'h00, 15'h7FFF, 15'h0000);
        gate(8'hFF, 8'hFF, 15'h2A55, 15'h2A55);
        wr(ieg_pkg::IEG_ADDR_MAIN, 8'h5A);
        wr(ieg_pkg::IEG_ADDR_EXT, 8'hC3);
        rd(ieg_pkg::IEG_ADDR_MAIN, 8'h5A);
        rd(ieg_pkg::IEG_ADDR_EXT, 8'hC3);
        wr(8'hA9, 8'hFF);
        rd(8'hA9, 8'h00);
        rd(ieg_pkg::IEG_ADDR_MAIN, 8'h5A);
        check({7'h00, ie_ext}, {7'h00, 8'hC3});
        bw(8'hAF, 1'b1, 8'hDA);
        bw(8'hB0, 1'b0, 8'hDA);
        bw(8'hA9, 1'b0, 8'hD8);
        // Byte write and bit write to the main register in one cycle
        @(posedge i_ref_clk);
        bus.addr  <= ieg_pkg::IEG_ADDR_MAIN;
        bus.wdata <= 8'h11;
        bus.wr    <= 1'b1;
        bit_addr  <= 8'hAF;
        bit_val   <= 1'b1;
        bit_wr    <= 1'b1;
        @(posedge i_ref_clk);
        bus.wr    <= 1'b0;
        bit_wr    <= 1'b0;
        @(negedge i_ref_clk);
        check({7'h00, ie_main}, 15'h0011);
        // Reset in mid-run returns both registers and the requests to idle
        @(posedge i_ref_clk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        @(negedge i_ref_clk);
        check({7'h00, ie_main}, 15'h0000);
        check({7'h00, ie_ext}, 15'h0000);
        check(irq_req, 15'h0000);
        rd(ieg_pkg::IEG_ADDR_MAIN, 8'h00);
        rd(ieg_pkg::IEG_ADDR_EXT, 8'h00);
        end_of_test;
    end
endmodule
